//--- design/curb_pkg.sv
package curb_pkg;
   // Register byte offsets within the window
   localparam logic [7:0] CURB_OFS_CONTROL      = 8'h00;
   localparam logic [7:0] CURB_OFS_CONFIG       = 8'h04;
   localparam logic [7:0] CURB_OFS_POWER        = 8'h08;
   localparam logic [7:0] CURB_OFS_INVALIDATE   = 8'h0c;
   localparam logic [7:0] CURB_OFS_FILT_START   = 8'h40;
   localparam logic [7:0] CURB_OFS_FILT_END     = 8'h44;
   localparam logic [7:0] CURB_OFS_SEC_ACCESS   = 8'h50;
   localparam logic [7:0] CURB_OFS_NS_ACCESS    = 8'h54;
   // Control register field positions
   localparam int CURB_CTL_ENABLE     = 0;
   localparam int CURB_CTL_FILTER     = 1;
   localparam int CURB_CTL_PARITY     = 2;
   localparam int CURB_CTL_SPEC_FILL  = 3;
   localparam int CURB_CTL_FORCE_DEV0 = 4;
   localparam int CURB_CTL_UNIT_STBY  = 5;
   localparam int CURB_CTL_IC_STBY    = 6;
   localparam int CURB_CTL_WIDTH      = 7;
   // Reset values
   localparam logic [31:0] CURB_RST_SEC_ACCESS = 32'h0000000f;
   localparam logic [31:0] CURB_RST_NS_ACCESS  = 32'h00000000;
   localparam logic [31:0] CURB_RST_POWER      = 32'h00000000;
   // Window: private region offsets 0x000-0x0fc belong to this bank
   localparam logic [12:8] CURB_WINDOW_PAGE = 5'h00;
   // Filter registers keep 1 MB granularity in bits [31:20]
   localparam int CURB_FILT_LSB = 20;
endpackage

//--- design/curb_regs.sv
// Added by the designer: the APB register port.
`timescale 1ns/100ps
// Summary of operation
// - All writable registers take byte writes; all reset by the coherency unit reset.
// - Offsets decode relative to private region base bits [31:13].
// - Writes to guarded registers need bit 0 of the secure access control register.
// - Configuration supports one to four cores with bus master connections.
// - Level-one data caches of attached cores are kept coherent.
// - Instruction cache coherency is left to software.
// - Core level-two requests are arbitrated and issued on master port.
// - Control holds linefill, port-zero, standby, parity, filter, unit enables.
// - Control bit 6 enables interrupt controller clock gating.
// - Control bit 5 enables coherency unit clock gating.
// - Control bit 3 enables speculative linefills.
// - Filter start/end reset to filter start/end inputs.
// - Idle output shows the coherency unit has no activity.
// - Device accesses are steered by the filter window when enabled.
// - Invalidate-all register is secure, write-only at 0x0c, reads zero.
// - Filter enable bit resets to filter enable input sampled at reset release.
// - Accelerator ready outputs held low while unit clock is gated.
// - Accelerator port cannot access registers of the private region.

// Register map, byte offsets inside the window
// 0x00 control            RW, guarded by the access control enables
// 0x04 configuration      RO, core count and per-core wait flags
// 0x08 power status       RW, guarded, plain word reset to zero
// 0x0c invalidate all     WO, secure only, always reads zero
// 0x40 filter start       RW, guarded, kept at 1 MB granularity
// 0x44 filter end         RW, guarded, kept at 1 MB granularity
// 0x50 secure access      RW from secure state, read-only otherwise
// 0x54 non-secure access  RW from secure state, read-only otherwise
//
// Control fields
// bit 0 unit enable, bit 1 address filtering, bit 2 RAM parity
// bit 3 speculative linefills, bit 4 device requests to port zero
// bit 5 unit standby, bit 6 interrupt controller standby
//
// Configuration fields
// bits [1:0] core count minus one, bits [7:4] per-core wait flags
//
// Invalidate: byte lane c with any bit set pulses core c for one cycle.
// Filter window: start inclusive, end exclusive.
// Reset: filter registers and the filter enable load from their inputs
// on the first clock edge after reset release.
// Non-secure writes need bit 0 of both access control registers.
// Accelerator port and out-of-window accesses answer with a slave error.
// Unused offsets in the window read zero and drop writes.
// Idle output: registered, one cycle behind the busy and request inputs.
// Clock stop: all state sits in flops with no timers, so a stopped clock
// simply freezes the bank.
// Bus timing: zero wait states, read data registered in the setup cycle,
// so a read never stalls the core that issued it.
// Limitation: bit 0 of each access control register guards every register,
// so software cannot unlock one register without the others.
// Hazard: clearing secure access bit 0 locks the bank until the next reset.
module curb_regs
   import curb_pkg::*;
#(
   parameter int NUM_CORES = 4
)
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   input  wire logic [2:0]  pprot,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [31:0] private_region_base,
   input  wire logic        acp_access,
   input  wire logic [31:0] filter_start_input,
   input  wire logic [31:0] filter_end_input,
   input  wire logic        filter_enable_input,
   input  wire logic [NUM_CORES-1:0] core_wfi,
   input  wire logic        acp_request,
   input  wire logic        unit_busy,
   input  wire logic        device_access,
   input  wire logic [31:0] device_addr,
   output logic             device_to_filter_port,
   output logic             device_force_port0,
   output logic             speculative_fill_en,
   output logic             parity_en,
   output logic             unit_enable,
   output logic             unit_clock_gated,
   output logic             ic_standby_en,
   output logic             acp_ready_enable,
   output logic             coherency_idle_out,
   output logic [NUM_CORES-1:0] invalidate_pulse
);

   // Refuse configurations the decode cannot serve
   initial
   begin
      if (NUM_CORES < 1 || NUM_CORES > 4)
         $error("NUM_CORES must be 1 to 4");
      if (CURB_FILT_LSB < 1 || CURB_FILT_LSB > 31)
         $error("filter granularity out of range");
      if (CURB_CTL_WIDTH > 8)
         $error("control register wider than one byte lane");
   end

   // Register state; retained while pclk stands still
   logic [CURB_CTL_WIDTH-1:0] control;
   logic [31:0]               power_status;
   logic [31:0]               filt_start;
   logic [31:0]               filt_end;
   logic [3:0]                sec_access;
   logic [11:0]               ns_access;
   logic                      reset_seen;
   logic                      unit_idle_q;

   // Byte-lane merge shared by every writable register except invalidate-all
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
            r[8*i +: 8] = nw[8*i +: 8];
      end
      return r;
   endfunction

   // Keeps the upper address bits of a filter boundary, clearing the rest
   function automatic logic [31:0] filter_align(input logic [31:0] a);
      logic [31:0] r;
      r = a;
      r[CURB_FILT_LSB-1:0] = '0;
      return r;
   endfunction

   // Write permission for a guarded register: secure needs the secure
   // enable, non-secure also needs the non-secure enable
   function automatic logic may_write(input logic sec, input logic secure_access_control, input logic nsac);
      return secure_access_control && (sec || nsac);
   endfunction

   // Address decode against the private region base
   wire         in_region  = (paddr[31:13] == private_region_base[31:13]);
   wire         in_window  = in_region && (paddr[12:8] == CURB_WINDOW_PAGE);
   wire  [7:0]  offset     = {paddr[7:2], 2'b00};
   wire         secure     = !pprot[1];
   // Bus phases: read data is picked in setup, writes land in access
   wire         setup_ph   = psel && !penable;
   wire         access_ph  = psel && penable;
   wire         access     = access_ph && !acp_access && in_window;
   wire         wr         = access && pwrite;
   wire         refused    = access_ph && (acp_access || !in_window);

   // Per-register hit
   wire hit_ctl  = offset == CURB_OFS_CONTROL;
   wire hit_cfg  = offset == CURB_OFS_CONFIG;
   wire hit_pwr  = offset == CURB_OFS_POWER;
   wire hit_inv  = offset == CURB_OFS_INVALIDATE;
   wire hit_fs   = offset == CURB_OFS_FILT_START;
   wire hit_fe   = offset == CURB_OFS_FILT_END;
   wire hit_sac  = offset == CURB_OFS_SEC_ACCESS;
   wire hit_nsac = offset == CURB_OFS_NS_ACCESS;

   // Write permission: secure needs the access control bit; non-secure also needs
   // the matching non-secure bit
   wire sac_ok   = sec_access[0];
   wire nsac_ok  = ns_access[0];
   wire wr_ok    = may_write(secure, sac_ok, nsac_ok);
   wire wr_ctl   = wr && hit_ctl && wr_ok;
   wire wr_pwr   = wr && hit_pwr && wr_ok;
   wire wr_fs    = wr && hit_fs  && wr_ok;
   wire wr_fe    = wr && hit_fe  && wr_ok;
   wire wr_inv   = wr && hit_inv && secure && sac_ok;
   wire wr_sac   = wr && hit_sac && secure && sac_ok;
   wire wr_nsac  = wr && hit_nsac && secure && sac_ok;

   // Registers narrower than a word, padded with zeros for read and merge
   wire [31:0] ctl_word  = {25'h0, control};
   wire [31:0] sac_word  = {28'h0, sec_access};
   wire [31:0] nsac_word = {20'h0, ns_access};

   // Merged write values, byte accessible
   wire [31:0] ctl_merged  = merge(ctl_word, pwdata, pstrb);
   wire [31:0] pwr_merged  = merge(power_status, pwdata, pstrb);
   wire [31:0] fs_merged   = merge(filt_start, pwdata, pstrb);
   wire [31:0] fe_merged   = merge(filt_end, pwdata, pstrb);
   wire [31:0] sac_merged  = merge(sac_word, pwdata, pstrb);
   wire [31:0] nsac_merged = merge(nsac_word, pwdata, pstrb);

   // Configuration word: core count minus one, and per-core wfi flags
   // Cores that are not built read as running, never as waiting
   wire [1:0]  core_count  = 2'(NUM_CORES - 1);
   wire [3:0]  wfi_nibble  = 4'(core_wfi);
   wire [31:0] config_word = {24'h0, wfi_nibble, 2'b00, core_count};

   // Read mux; invalidate and unused offsets read zero
   // Order does not matter: the hit wires are one-hot by construction
   wire [31:0] read_value =
      hit_ctl  ? ctl_word :
      hit_cfg  ? config_word :
      hit_pwr  ? power_status :
      hit_fs   ? filt_start :
      hit_fe   ? filt_end :
      hit_sac  ? sac_word :
      hit_nsac ? nsac_word :
                 32'h00000000;

   // Reset then filter defaults are loaded on the first edge after release, since an
   // async reset may not load a port value; the first bus setup can only
   // come one edge later, so software never sees the zeros
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         reset_seen <= 1'b0;
      else
         reset_seen <= 1'b1;
   end

   // Control register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         control <= '0;
      else if (!reset_seen)
         control[CURB_CTL_FILTER] <= filter_enable_input;
      else if (wr_ctl)
         control <= ctl_merged[CURB_CTL_WIDTH-1:0];
   end

   // Filter window start, kept at 1 MB granularity
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         filt_start <= '0;
      else if (!reset_seen)
         filt_start <= filter_align(filter_start_input);
      else if (wr_fs)
         filt_start <= filter_align(fs_merged);
   end

   // Filter window end, same granularity as the start
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         filt_end <= '0;
      else if (!reset_seen)
         filt_end <= filter_align(filter_end_input);
      else if (wr_fe)
         filt_end <= filter_align(fe_merged);
   end

   // Power status, plain word
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         power_status <= CURB_RST_POWER;
      else if (wr_pwr)
         power_status <= pwr_merged;
   end

   // Secure access control; only its bit 0 gates writes
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         sec_access <= CURB_RST_SEC_ACCESS[3:0];
      else if (wr_sac)
         sec_access <= sac_merged[3:0];
   end

   // Non-secure access control; non-secure writes never reach it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ns_access <= CURB_RST_NS_ACCESS[11:0];
      else if (wr_nsac)
         ns_access <= nsac_merged[11:0];
   end

   // Invalidate-all: one-cycle pulse per core whose byte has any bit set
   // Lanes of cores that are not built are ignored
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         invalidate_pulse <= '0;
      else
      begin
         for (int c = 0; c < NUM_CORES; c++)
            invalidate_pulse[c] <= wr_inv && pstrb[c] && (pwdata[8*c +: 8] != 8'h00);
      end
   end

   // Idle and clock gating: gated only when all cores wait and nothing is pending.
   // A core leaving its wait state ungates at once, as the gate term is
   // combinational on the wait flags
   wire all_wfi   = &core_wfi;
   wire next_idle = !unit_busy && !acp_request;
   // Idle is registered to keep glitches of the busy inputs off the pin
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         unit_idle_q <= 1'b0;
      else
         unit_idle_q <= next_idle;
   end

   // APB answer: zero wait states; refused and region misses flag an error
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= '0;
      // Loading in setup lets the access phase answer with no wait state
      else if (setup_ph && !pwrite)
         prdata <= read_value;
   end

   assign pready  = 1'b1;
   assign pslverr = refused;

   // Control outputs into the coherency datapath
   assign unit_enable         = control[CURB_CTL_ENABLE];
   assign parity_en           = control[CURB_CTL_PARITY];
   assign speculative_fill_en = control[CURB_CTL_SPEC_FILL];
   assign device_force_port0  = control[CURB_CTL_FORCE_DEV0];
   // Standby enables; the unit gate also needs every core waiting
   assign ic_standby_en       = control[CURB_CTL_IC_STBY];
   assign unit_clock_gated    = control[CURB_CTL_UNIT_STBY] && all_wfi && unit_idle_q;
   assign acp_ready_enable    = !unit_clock_gated;
   assign coherency_idle_out  = unit_idle_q;

   // Filter steering of device accesses, inclusive start, exclusive end
   wire above_start = device_addr >= filt_start;
   wire below_end   = device_addr < filt_end;
   // An empty or inverted window steers nothing
   assign device_to_filter_port = control[CURB_CTL_FILTER] && device_access
                                  && above_start && below_end;

endmodule

//--- dv/curb_props.sv
`timescale 1ns/100ps
module curb_props
#(parameter int NUM_CORES = 4)
(
   input wire logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr,
   input wire logic                 acp_access, acp_request, unit_busy, unit_clock_gated,
   input wire logic                 acp_ready_enable, coherency_idle_out,
   input wire logic [31:0]          paddr, prdata, private_region_base,
   input wire logic [2:0]           pprot,
   input wire logic [NUM_CORES-1:0] core_wfi, invalidate_pulse
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Window decode seen from the bus side
   wire hit    = paddr[31:13] == private_region_base[31:13] && paddr[12:8] == 5'h00;
   wire mapped = {paddr[7:2], 2'b00} inside {8'h00, 8'h04, 8'h08, 8'h40, 8'h44, 8'h50, 8'h54};
   logic inv_wr_q;
   // Remembers a secure invalidate write, the only legal cause of a pulse
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         inv_wr_q <= 1'b0;
      else
         inv_wr_q <= psel && penable && pwrite && hit && paddr[7:0] == 8'h0c && !pprot[1];
   end
   sequence acc_s;
      psel && penable;
   endsequence
   sequence hit_acc_s;
      acc_s ##0 (hit && !acp_access);
   endsequence
   zero_wait_a: assert property (acc_s |-> pready)
      else $error("access phase without ready");
   window_miss_a: assert property (acc_s ##0 !hit |-> pslverr)
      else $error("access outside window not refused");
   window_hit_a: assert property (hit_acc_s |-> !pslverr)
      else $error("access inside window refused");
   acp_refuse_a: assert property (acc_s ##0 acp_access |-> pslverr)
      else $error("accelerator access not refused");
   reads_zero_a: assert property
      (hit_acc_s ##0 (!pwrite && !mapped) |-> prdata == 32'h0)
      else $error("unmapped or write-only offset read nonzero");
   inv_cause_a: assert property ((|invalidate_pulse) |-> inv_wr_q)
      else $error("invalidate pulse without secure write");
   gate_cond_a: assert property (unit_clock_gated |-> (&core_wfi) && $past(presetn))
      else $error("unit gated while a core runs");
   ready_low_a: assert property (unit_clock_gated |-> !acp_ready_enable)
      else $error("accelerator ready while gated");
   idle_out_a: assert property ($past(presetn) |->
      coherency_idle_out == !$past(unit_busy || acp_request))
      else $error("idle output wrong");
endmodule
bind curb_regs curb_props #(.NUM_CORES(NUM_CORES)) u_props (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
   .acp_access(acp_access), .acp_request(acp_request), .unit_busy(unit_busy),
   .unit_clock_gated(unit_clock_gated), .acp_ready_enable(acp_ready_enable),
   .coherency_idle_out(coherency_idle_out), .paddr(paddr), .prdata(prdata),
   .private_region_base(private_region_base), .pprot(pprot), .core_wfi(core_wfi),
   .invalidate_pulse(invalidate_pulse));

//--- dv/curb_apb_master.sv
`timescale 1ns/100ps
module curb_apb_master
(
   input  wire logic        pclk, pready, pslverr,
   input  wire logic [31:0] prdata,
   output logic             psel = 0, penable = 0, pwrite = 0, rsp_valid = 0,
   output logic [31:0]      paddr = 0, pwdata = 0,
   output logic [3:0]       pstrb = 0,
   output logic [2:0]       pprot = 0,
   output logic [32:0]      rsp = 0
);
   // One plain word or byte-lane transfer at a time, never a vector burst
   task xfer(input logic w, input logic [31:0] a, d, input logic [3:0] s, input logic [2:0] p);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata, pstrb, pprot} <= {2'b10, w, a, d, s, p};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rsp <= {pslverr, (pwrite || pslverr) ? 32'h0 : prdata};
      rsp_valid <= 1'b1;
      {psel, penable} <= 2'b00;
      paddr <= ~a; // Released lines must not keep their last value
      pwdata <= ~d;
   endtask
   // Response strobe lasts one cycle
   always @(posedge pclk)
      if (rsp_valid)
         rsp_valid <= 1'b0;
endmodule

//--- dv/curb_regs_bench.sv
`timescale 1ns/100ps
module curb_regs_bench import curb_pkg::*;;
   logic        pclk = 0, presetn = 0, clk_run = 1, psel, penable, pwrite, pready, pslverr;
   logic        rv, accelerator_coherency_port = 0, fen = 1, acp_req = 0, busy = 0, dev_acc = 0;
   logic        to_filt, fdev0, spec, par, uen, gated, icsb, acp_rdy, idle;
   logic [31:0] paddr, pwdata, prdata, d, base = 0, dev_addr = 0;
   logic [31:0] fs_in = 32'h12345678, fe_in = 32'habcde000;
   logic [3:0]  pstrb, inv, inv_seen = 0, wait_for_interrupt_state = 0;
   logic [2:0]  pprot;
   logic [32:0] rsp, exp_q[$];
   int          n_errors = 0, total_checks = 0, seed = 32'h9e42;
   // Clock can be held still to show registers survive a stopped clock
   initial forever #20 if (clk_run) pclk = ~pclk;
   curb_apb_master u_mst (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
      .psel(psel), .penable(penable), .pwrite(pwrite), .rsp_valid(rv), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .pprot(pprot), .rsp(rsp));
   curb_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pprot(pprot),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .private_region_base(base),
      .acp_access(accelerator_coherency_port), .filter_start_input(fs_in), .filter_end_input(fe_in),
      .filter_enable_input(fen), .core_wfi(wait_for_interrupt_state), .acp_request(acp_req), .unit_busy(busy),
      .device_access(dev_acc), .device_addr(dev_addr), .device_to_filter_port(to_filt),
      .device_force_port0(fdev0), .speculative_fill_en(spec), .parity_en(par),
      .unit_enable(uen), .unit_clock_gated(gated), .ic_standby_en(icsb),
      .acp_ready_enable(acp_rdy), .coherency_idle_out(idle), .invalidate_pulse(inv));
   task check(input string what, input logic [32:0] got, exp);
      total_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task wr(input logic [11:0] off, input logic [31:0] v, input logic [3:0] s, input logic ns);
      exp_q.push_back(33'h0);
      u_mst.xfer(1'b1, {base[31:13], 1'b0, off}, v, s, {1'b0, ns, 1'b0});
   endtask
   task rd(input logic [11:0] off, input logic [31:0] v, input logic err);
      exp_q.push_back({err, v});
      u_mst.xfer(1'b0, {base[31:13], 1'b0, off}, 32'h0, 4'h0, 3'h0);
   endtask
   task final_report;
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Response checker and invalidate pulse catcher
   always @(posedge pclk)
   begin
      if (rv === 1'b1)
         check("apb response", rsp, exp_q.pop_front());
      if (inv !== 4'h0)
         inv_seen <= inv;
   end
   initial
   begin
      #200000;
      n_errors++;
      final_report;
   end
   initial
   begin
      base = $random(seed);
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      rd(CURB_OFS_SEC_ACCESS, 32'hf, 0);
      rd(CURB_OFS_NS_ACCESS, 32'h0, 0);
      rd(CURB_OFS_FILT_START, 32'h12300000, 0);
      rd(CURB_OFS_FILT_END, 32'hab_c00000, 0);
      rd(CURB_OFS_CONTROL, 32'h2, 0);
      rd(CURB_OFS_CONFIG, 32'h3, 0);
      $display("reset values done");
      wr(CURB_OFS_CONTROL, 32'hffffffff, 4'hf, 0);
      rd(CURB_OFS_CONTROL, 32'h7f, 0);
      wr(CURB_OFS_CONTROL, 32'h48, 4'hf, 0);
      @(negedge pclk);
      check("control outputs", {icsb, fdev0, spec, par, uen}, 5'b10100);
      d = $random(seed);
      wr(CURB_OFS_POWER, d, 4'b0010, 0);
      rd(CURB_OFS_POWER, {16'h0, d[15:8], 8'h0}, 0);
      wr(CURB_OFS_FILT_START, 32'h00100000, 4'hf, 0);
      wr(CURB_OFS_FILT_END, 32'h00300000, 4'hf, 0);
      wr(CURB_OFS_CONTROL, 32'h2, 4'hf, 0);
      foreach (fs_in[i])
         if (i < 3)
         begin
            @(posedge pclk);
            dev_acc <= 1'b1;
            dev_addr <= (i == 0) ? 32'h00200000 : (i == 1) ? 32'h00300000 : 32'h000fffff;
            @(negedge pclk);
            check("filter steer", to_filt, i == 0);
         end
      $display("control and filter done");
      wr(12'h020, 32'hffffffff, 4'hf, 0);
      rd(12'h020, 32'h0, 0);
      rd(12'h100, 32'h0, 1);
      @(posedge pclk);
      accelerator_coherency_port <= 1'b1;
      rd(CURB_OFS_CONTROL, 32'h0, 1);
      accelerator_coherency_port <= 1'b0;
      inv_seen = 0;
      wr(CURB_OFS_INVALIDATE, 32'hffffffff, 4'b0101, 0);
      rd(CURB_OFS_INVALIDATE, 32'h0, 0);
      check("invalidate lanes", inv_seen, 4'b0101);
      inv_seen = 0;
      wr(CURB_OFS_INVALIDATE, 32'hffffffff, 4'hf, 1);
      repeat (2) @(posedge pclk);
      check("nonsecure invalidate", inv_seen, 4'h0);
      $display("refusals and invalidate done");
      wr(CURB_OFS_CONTROL, 32'h20, 4'hf, 0);
      @(posedge pclk);
      {wait_for_interrupt_state, busy} <= 5'h1f;
      @(posedge pclk);
      busy <= 1'b0;
      repeat (4) @(posedge pclk);
      @(negedge pclk);
      check("gated", {gated, acp_rdy, idle}, 3'b101);
      rd(CURB_OFS_CONFIG, 32'hf3, 0);
      @(posedge pclk);
      acp_req <= 1'b1;
      repeat (3) @(posedge pclk);
      @(negedge pclk);
      check("woken", {gated, acp_rdy, idle}, 3'b010);
      @(posedge pclk);
      {wait_for_interrupt_state, acp_req} <= 5'h0;
      wr(CURB_OFS_POWER, 32'h5a5a5a5a, 4'hf, 0);
      @(negedge pclk);
      clk_run = 0;
      #2000 clk_run = 1;
      rd(CURB_OFS_POWER, 32'h5a5a5a5a, 0);
      $display("gating and clock stop done");
      wr(CURB_OFS_POWER, 32'h0, 4'hf, 1);
      rd(CURB_OFS_POWER, 32'h5a5a5a5a, 0);
      wr(CURB_OFS_NS_ACCESS, 32'h1, 4'hf, 1);
      rd(CURB_OFS_NS_ACCESS, 32'h0, 0);
      wr(CURB_OFS_NS_ACCESS, 32'h1, 4'hf, 0);
      wr(CURB_OFS_POWER, 32'h11, 4'hf, 1);
      rd(CURB_OFS_POWER, 32'h11, 0);
      wr(CURB_OFS_SEC_ACCESS, 32'h0, 4'hf, 0);
      wr(CURB_OFS_POWER, 32'h22, 4'hf, 0);
      rd(CURB_OFS_POWER, 32'h11, 0);
      $display("access control done");
      repeat (2) @(posedge pclk);
      final_report;
   end
endmodule
